//--- design/sgtc_pkg.sv
// Purpose: Shared constants for the shared global timer with per-processor comparators.
// Assumes: Register offsets are byte addresses inside the timer's private window.
// Notes:   All registers reset to zero.
package sgtc_pkg;
	localparam int          NUM_CPU        = 2;
	localparam int          CPU_ID_W       = 1;
	localparam int          ADDR_W         = 5;
	localparam int          DATA_W         = 32;
	localparam int          CNT_W          = 64;
	localparam int          PRESC_W        = 8;

	localparam logic [4:0]  OFF_CNT_LO     = 5'h00;
	localparam logic [4:0]  OFF_CNT_HI     = 5'h04;
	localparam logic [4:0]  OFF_CTRL       = 5'h08;
	localparam logic [4:0]  OFF_STATUS     = 5'h0C;
	localparam logic [4:0]  OFF_CMP_LO     = 5'h10;
	localparam logic [4:0]  OFF_CMP_HI     = 5'h14;
	localparam logic [4:0]  OFF_STEP       = 5'h18;

	localparam int          TIMER_EN_BIT   = 0;
	localparam int          CMP_EN_BIT     = 1;
	localparam int          IRQ_EN_BIT     = 2;
	localparam int          AUTO_INC_BIT   = 3;
	localparam int          PRESC_LSB      = 8;
	localparam int          EVENT_BIT      = 0;

	localparam logic [31:0] REG_RESET      = 32'h0000_0000;
	localparam logic [63:0] CNT_RESET      = 64'h0000_0000_0000_0000;
	localparam logic [7:0]  PRESC_RESET    = 8'h00;
	// Private interrupt number that the per-processor interrupt line stands for.
	localparam int          TIMER_IRQ_ID   = 27;
endpackage

//--- design/sgtc_top.sv
// Purpose: Shared 64-bit global timer with one banked comparator per processor.
// Assumes: Cores sit on the peripheral clock; one access per cycle, tagged with the core's id.
// Notes:   Counter, prescaler and timer enable are shared; other control bits are banked.
//
// Contract
// - One shared 64-bit up-counter that keeps counting after interrupts.
// - Each processor has a private 64-bit comparator raising its private interrupt.
// - Comparator accesses reach only the requesting processor's own bank.
// - A comparator's interrupt goes only to its owning processor.
// - Counter and comparators run on the peripheral clock.
// - Match is counter greater than or equal to comparator.
// - Counter keeps counting while any processor is in debug state.
// - All timer registers clear to zero on peripheral reset.
// - Counter low word at 0x00, high at 0x04, single 32-bit accesses.
// - Control bits 15 to 8 prescale the counter tick period.
// - Auto-increment clear: match sets flag, comparator stays unchanged.
// - Auto-increment set: each match adds the step value to the comparator.
// - Interrupt enable bit 2 turns a set event flag into interrupt 27.
// - Compare enable bit 1 gates comparison; cleared means no match.
// - Timer enable bit 0 clear holds the counter; registers stay accessible.
// - Event flag is sticky; writing one clears it, zero does nothing.
`timescale 1ns/100ps
`default_nettype none
module sgtc_top
	import sgtc_pkg::*;
(
	input  wire logic                mclk_in,
	input  wire logic                rst_n_in,
	input  wire logic                reg_valid_in,
	input  wire logic                reg_write_in,
	input  wire logic [ADDR_W-1:0]   reg_addr_in,
	input  wire logic [DATA_W-1:0]   reg_wdata_in,
	input  wire logic [CPU_ID_W-1:0] reg_cpu_in,
	output logic      [DATA_W-1:0]   reg_rdata_out,
	output logic                     reg_ready_out,
	output logic      [NUM_CPU-1:0]  timer_irq_out
);

	logic [CNT_W-1:0]   count_q;
	logic [CNT_W-1:0]   count_d;
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] ps_cnt_q;
	logic               timer_en_q;
	logic [CNT_W-1:0]   comp_q   [NUM_CPU];
	logic [DATA_W-1:0]  step_q   [NUM_CPU];
	logic [NUM_CPU-1:0] cmp_en_q;
	logic [NUM_CPU-1:0] irq_en_q;
	logic [NUM_CPU-1:0] auto_q;
	logic [NUM_CPU-1:0] flag_q;
	logic [NUM_CPU-1:0] irq_q;
	logic [DATA_W-1:0]  rdata_q;
	logic               ready_q;

	// Address decode.
	wire logic          wr_en      = reg_valid_in & reg_write_in;
	wire logic          wr_cnt_lo  = wr_en & (reg_addr_in == OFF_CNT_LO);
	wire logic          wr_cnt_hi  = wr_en & (reg_addr_in == OFF_CNT_HI);
	wire logic          wr_ctrl    = wr_en & (reg_addr_in == OFF_CTRL);
	wire logic          wr_status  = wr_en & (reg_addr_in == OFF_STATUS);
	wire logic          wr_cmp_lo  = wr_en & (reg_addr_in == OFF_CMP_LO);
	wire logic          wr_cmp_hi  = wr_en & (reg_addr_in == OFF_CMP_HI);
	wire logic          wr_step    = wr_en & (reg_addr_in == OFF_STEP);

	// Debug state of any core is deliberately not an input: only a cleared timer enable stops the count.
	// Greater-or-equal means a prescaler lowered below the running count ticks at once
	// instead of waiting for the eight-bit count to wrap all the way round.
	wire logic          tick       = timer_en_q & (ps_cnt_q >= presc_q);

	logic [NUM_CPU-1:0] own;
	logic [NUM_CPU-1:0] match;
	always_comb begin
		for (int c = 0; c < NUM_CPU; c++) begin
			own[c]   = (reg_cpu_in == CPU_ID_W'(c));
			match[c] = cmp_en_q[c] & (count_q >= comp_q[c]);
		end
	end

	always_comb begin
		count_d = count_q;
		if (tick) begin
			count_d = count_q + 64'h0000_0000_0000_0001;
		end
		if (wr_cnt_lo) begin
			count_d[31:0] = reg_wdata_in;
		end
		if (wr_cnt_hi) begin
			count_d[63:32] = reg_wdata_in;
		end
	end

	// Read multiplexer; banked words come from the requester's own copy only.
	wire logic [DATA_W-1:0] rd_ctrl = {16'h0000, presc_q, 4'h0, auto_q[reg_cpu_in],
		irq_en_q[reg_cpu_in], cmp_en_q[reg_cpu_in], timer_en_q};
	logic [DATA_W-1:0] rd_word;
	always_comb begin
		unique case (reg_addr_in)
			OFF_CNT_LO: rd_word = count_q[31:0];
			OFF_CNT_HI: rd_word = count_q[63:32];
			OFF_CTRL:   rd_word = rd_ctrl;
			OFF_STATUS: rd_word = {31'h0000_0000, flag_q[reg_cpu_in]};
			OFF_CMP_LO: rd_word = comp_q[reg_cpu_in][31:0];
			OFF_CMP_HI: rd_word = comp_q[reg_cpu_in][63:32];
			OFF_STEP:   rd_word = step_q[reg_cpu_in];
			default:    rd_word = REG_RESET;
		endcase
	end

	// Shared counter, prescaler and timer enable, all on the peripheral clock.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_q    <= CNT_RESET;
			presc_q    <= PRESC_RESET;
			ps_cnt_q   <= PRESC_RESET;
			timer_en_q <= 1'b0;
		end else begin
			count_q <= count_d;
			if (!timer_en_q || tick) begin
				ps_cnt_q <= PRESC_RESET;
			end else begin
				ps_cnt_q <= ps_cnt_q + 8'h01;
			end
			if (wr_ctrl) begin
				presc_q    <= reg_wdata_in[PRESC_LSB +: PRESC_W];
				timer_en_q <= reg_wdata_in[TIMER_EN_BIT];
			end
		end
	end

	// Per-processor banks.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int c = 0; c < NUM_CPU; c++) begin
				comp_q[c] <= CNT_RESET;
				step_q[c] <= REG_RESET;
			end
			cmp_en_q <= '0;
			irq_en_q <= '0;
			auto_q   <= '0;
			flag_q   <= '0;
			irq_q    <= '0;
		end else begin
			for (int c = 0; c < NUM_CPU; c++) begin
				if (wr_cmp_lo && own[c]) begin
					comp_q[c][31:0] <= reg_wdata_in;
				end else if (wr_cmp_hi && own[c]) begin
					comp_q[c][63:32] <= reg_wdata_in;
				end else if (match[c] && auto_q[c]) begin
					comp_q[c] <= comp_q[c] + {32'h0000_0000, step_q[c]};
				end
				if (wr_step && own[c]) begin
					step_q[c] <= reg_wdata_in;
				end
				if (wr_ctrl && own[c]) begin
					cmp_en_q[c] <= reg_wdata_in[CMP_EN_BIT];
					irq_en_q[c] <= reg_wdata_in[IRQ_EN_BIT];
					auto_q[c]   <= reg_wdata_in[AUTO_INC_BIT];
				end
				// A match in the cycle of a clear keeps the flag set, so no event is lost.
				if (match[c]) begin
					flag_q[c] <= 1'b1;
				end else if (wr_status && own[c] && reg_wdata_in[EVENT_BIT]) begin
					flag_q[c] <= 1'b0;
				end
				irq_q[c] <= flag_q[c] & irq_en_q[c];
			end
		end
	end

	// Register port answer: one cycle after every access.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= REG_RESET;
			ready_q <= 1'b0;
		end else begin
			ready_q <= reg_valid_in;
			rdata_q <= (reg_valid_in && !reg_write_in) ? rd_word : REG_RESET;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign reg_ready_out = ready_q;
	assign timer_irq_out = irq_q;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	cnt_hold_a: assert property (!timer_en_q && !wr_cnt_lo && !wr_cnt_hi |=> $stable(count_q))
		else $error("Counter moved while the timer was disabled.");

	cnt_step_a: assert property (tick && !wr_cnt_lo && !wr_cnt_hi
		|=> count_q == $past(count_q) + 64'h0000_0000_0000_0001)
		else $error("Counter did not advance by one on a tick.");

	// A control write inside the gap may legally move the next tick, so the spacing is
	// judged only while the prescaler and the enable stay put.
	presc_gap_a: assert property ((tick && presc_q == 8'h02 && !wr_ctrl)
		##1 (!wr_ctrl)[*2] |-> !$past(tick) && !tick ##1 tick)
		else $error("Tick spacing does not follow the prescaler.");

	ps_clear_a: assert property (!timer_en_q || tick |=> ps_cnt_q == PRESC_RESET)
		else $error("Prescaler count did not restart.");

	ps_run_a: assert property (timer_en_q && !tick
		|=> ps_cnt_q == $past(ps_cnt_q) + 8'h01)
		else $error("Prescaler count did not advance between ticks.");

	wr_lo_a: assert property (wr_cnt_lo |=> count_q[31:0] == $past(reg_wdata_in))
		else $error("Counter low word write was lost.");

	wr_hi_a: assert property (wr_cnt_hi |=> count_q[63:32] == $past(reg_wdata_in))
		else $error("Counter high word write was lost.");

	ctrl_wr_a: assert property (wr_ctrl
		|=> timer_en_q == $past(reg_wdata_in[TIMER_EN_BIT]))
		else $error("Timer enable did not follow the control write.");

	// The port answers every access exactly one cycle later and at no other time.
	rdy_pulse_a: assert property (reg_valid_in |=> reg_ready_out)
		else $error("An access was not answered in the next cycle.");

	rdy_idle_a: assert property (!reg_valid_in |=> !reg_ready_out)
		else $error("Ready rose without an access.");

	// Read data is zero outside a read answer, so a stale word is never taken for a fresh one.
	rd_quiet_a: assert property (!reg_valid_in || reg_write_in
		|=> reg_rdata_out == REG_RESET)
		else $error("Read data showed outside a read answer.");

	// Each processor's bank gets its own copy of the checks below.
	generate
		for (genvar g = 0; g < NUM_CPU; g++) begin : g_chk
			flag_set_a: assert property (cmp_en_q[g] && count_q >= comp_q[g] |=> flag_q[g])
				else $error("Comparator match did not set the event flag.");

			no_cmp_a: assert property (!cmp_en_q[g] && !flag_q[g] |=> !flag_q[g])
				else $error("Event flag set while compare was disabled.");

			one_shot_a: assert property (match[g] && !auto_q[g]
				&& !wr_cmp_lo && !wr_cmp_hi |=> $stable(comp_q[g]))
				else $error("Single-shot comparator changed without a write.");

			auto_inc_a: assert property (match[g] && auto_q[g]
				&& !wr_cmp_lo && !wr_cmp_hi
				|=> comp_q[g] == $past(comp_q[g]) + {32'h0000_0000, $past(step_q[g])})
				else $error("Auto-increment did not add the step value.");

			flag_clr_a: assert property (wr_status && own[g]
				&& reg_wdata_in[EVENT_BIT] && !match[g] |=> !flag_q[g])
				else $error("Writing one did not clear the event flag.");

			bank_iso_a: assert property ((wr_cmp_lo || wr_cmp_hi) && !own[g]
				&& !match[g] |=> $stable(comp_q[g]))
				else $error("Another processor changed this comparator.");

			// The interrupt is a registered level and lags its event flag by one cycle.
			irq_path_a: assert property (flag_q[g] && irq_en_q[g] |=> timer_irq_out[g])
				else $error("Enabled event flag did not raise the interrupt.");

			irq_own_a: assert property (timer_irq_out[g] |-> $past(flag_q[g]))
				else $error("Interrupt raised without this processor's flag.");

			irq_drop_a: assert property (!(flag_q[g] && irq_en_q[g])
				|=> !timer_irq_out[g])
				else $error("Interrupt stood without an enabled event flag.");

			flag_keep_a: assert property (flag_q[g]
				&& !(wr_status && own[g] && reg_wdata_in[EVENT_BIT]) |=> flag_q[g])
				else $error("Event flag dropped without a clearing write.");

			cmp_lo_a: assert property (wr_cmp_lo && own[g]
				|=> comp_q[g][31:0] == $past(reg_wdata_in))
				else $error("Comparator low word write was lost.");

			cmp_hi_a: assert property (wr_cmp_hi && own[g]
				|=> comp_q[g][63:32] == $past(reg_wdata_in))
				else $error("Comparator high word write was lost.");

			// Only a match or the owner's own write may move a comparator.
			cmp_still_a: assert property (!match[g]
				&& !(own[g] && (wr_cmp_lo || wr_cmp_hi)) |=> $stable(comp_q[g]))
				else $error("Comparator changed without a match or a write.");

			step_wr_a: assert property (wr_step && own[g]
				|=> step_q[g] == $past(reg_wdata_in))
				else $error("Step value write was lost.");

			step_iso_a: assert property (wr_step && !own[g] |=> $stable(step_q[g]))
				else $error("Another processor changed this step value.");

			// Shared fields may change from any core; the banked bits must not.
			ctrl_iso_a: assert property (wr_ctrl && !own[g]
				|=> $stable(cmp_en_q[g]) && $stable(irq_en_q[g]) && $stable(auto_q[g]))
				else $error("Another processor changed this processor's control bits.");
		end
	endgenerate

endmodule
`default_nettype wire

//--- tb/sgtc_core_model.sv
// Purpose: Processor-side model that issues single register accesses to the timer.
// Assumes: Each call presents one request for exactly one taken edge.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none
module sgtc_core_model
	import sgtc_pkg::*;
(
	input  wire logic                mclk_in,
	input  wire logic                ready_in,
	input  wire logic [DATA_W-1:0]   rdata_in,
	output logic                     valid_out,
	output logic                     write_out,
	output logic      [ADDR_W-1:0]   addr_out,
	output logic      [DATA_W-1:0]   wdata_out,
	output logic      [CPU_ID_W-1:0] cpu_out
);
	initial begin
		valid_out = 1'b0;
		write_out = 1'b0;
		addr_out = 5'h1F;
		wdata_out = 32'h0000_0000;
		cpu_out = 1'b0;
	end
	// Only single 32-bit transfers exist, so a 64-bit value always takes two calls.
	task automatic access(input logic w, input logic [CPU_ID_W-1:0] c,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic ok);
		@(negedge mclk_in);
		valid_out = 1'b1;
		write_out = w;
		cpu_out = c;
		addr_out = a;
		wdata_out = d;
		@(negedge mclk_in);
		ok = ready_in;
		q = rdata_in;
		valid_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/shared_global_timer_comparators_tb.sv
// Purpose: Self-checking bench for the shared timer with banked comparators.
// Assumes: Two cores share one register port, told apart by the core id.
// Notes:   Counter is frozen before compare scenarios so expectations stay exact.
`timescale 1ns/100ps
`default_nettype none
module shared_global_timer_comparators_tb;
	import sgtc_pkg::*;
	logic                mclk_in;
	logic                rst_n_in;
	logic                valid;
	logic                write;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [CPU_ID_W-1:0] cpu;
	logic [DATA_W-1:0]   rdata;
	logic                ready;
	logic [NUM_CPU-1:0]  irq;
	int                  n_mismatch;
	int                  tests_run;
	int                  cycles;
	sgtc_top i_sgtc_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .reg_valid_in(valid),
		.reg_write_in(write), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_cpu_in(cpu),
		.reg_rdata_out(rdata), .reg_ready_out(ready), .timer_irq_out(irq));
	sgtc_core_model i_sgtc_core_model (.mclk_in(mclk_in), .ready_in(ready), .rdata_in(rdata),
		.valid_out(valid), .write_out(write), .addr_out(addr), .wdata_out(wdata), .cpu_out(cpu));
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [0:0] c, input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        ok;
		i_sgtc_core_model.access(1'b1, c, a, d, q, ok);
		check({31'h0, ok}, 32'h1);
	endtask
	task automatic rd(input logic [0:0] c, input logic [4:0] a, output logic [31:0] q);
		logic ok;
		i_sgtc_core_model.access(1'b0, c, a, 32'h0, q, ok);
		check({31'h0, ok}, 32'h1);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		for (int k = 0; k < 16; k++) begin
			rd(k[3], 5'(k[2:0] * 4), q);
			check(q, 32'h0000_0000);
		end
	endtask
	task automatic t_presc();
		logic [31:0] a;
		logic [31:0] b;
		int          p [3] = '{0, 2, 5};
		for (int k = 0; k < 4; k++) begin
			if (k < 3) wr(1'b0, OFF_CTRL, {16'h0, 8'(p[k]), 8'h01});
			else wr(1'b1, OFF_CTRL, 32'h0000_0500);
			rd(1'b0, OFF_CNT_LO, a);
			repeat (28) @(negedge mclk_in);
			rd(1'b0, OFF_CNT_LO, b);
			check(b - a, (k < 3) ? 32'(30 / (p[k] + 1)) : 32'h0);
		end
	endtask
	task automatic t_carry();
		logic [31:0] h1;
		logic [31:0] h2;
		logic [31:0] l;
		wr(1'b0, OFF_CNT_LO, 32'hFFFF_FFF0);
		wr(1'b0, OFF_CNT_HI, 32'h0000_0005);
		wr(1'b0, OFF_CTRL, 32'h0000_0001);
		repeat (40) @(negedge mclk_in);
		rd(1'b0, OFF_CNT_HI, h2);
		do begin
			h1 = h2;
			rd(1'b0, OFF_CNT_LO, l);
			rd(1'b0, OFF_CNT_HI, h2);
		end while (h1 !== h2);
		check(h2, 32'h0000_0006);
		check(l, 32'h0000_001B);
	endtask
	task automatic t_bank();
		logic [31:0] q;
		wr(1'b0, OFF_CTRL, 32'h0000_0000);
		wr(1'b0, OFF_CNT_LO, 32'h0000_0064);
		wr(1'b0, OFF_CNT_HI, 32'h0000_0006);
		wr(1'b1, OFF_CMP_HI, 32'h0000_0006);
		wr(1'b1, OFF_CTRL, 32'h0000_0006);
		repeat (3) @(negedge mclk_in);
		check(32'(irq), 32'h2);
		rd(1'b0, OFF_STATUS, q);
		check(q, 32'h0);
		rd(1'b0, OFF_CMP_HI, q);
		check(q, 32'h0);
		rd(1'b1, OFF_CMP_HI, q);
		check(q, 32'h6);
		wr(1'b1, OFF_STATUS, 32'h0);
		rd(1'b1, OFF_STATUS, q);
		check(q, 32'h1);
		wr(1'b1, OFF_CTRL, 32'h0000_0004);
		wr(1'b1, OFF_STATUS, 32'h1);
		repeat (3) @(negedge mclk_in);
		rd(1'b1, OFF_STATUS, q);
		check(q, 32'h0);
		check(32'(irq), 32'h0);
		rd(1'b1, OFF_CTRL, q);
		check(q, 32'h4);
	endtask
	task automatic t_auto();
		logic [31:0] q;
		wr(1'b0, OFF_STEP, 32'h0000_000A);
		wr(1'b0, OFF_CMP_LO, 32'h0000_004B);
		wr(1'b0, OFF_CMP_HI, 32'h0000_0006);
		wr(1'b0, OFF_CTRL, 32'h0000_000A);
		repeat (6) @(negedge mclk_in);
		rd(1'b0, OFF_CMP_LO, q);
		check(q, 32'h0000_0069);
		rd(1'b0, OFF_STATUS, q);
		check(q, 32'h1);
		check(32'(irq), 32'h0);
	endtask
	// Reset in mid-run, with every bank holding non-zero state and an interrupt up.
	task automatic t_rerst();
		wr(1'b0, OFF_CTRL, 32'h0000_0004);
		repeat (2) @(negedge mclk_in);
		check(32'(irq), 32'h1);
		rst_n_in = 1'b0;
		repeat (4) @(negedge mclk_in);
		rst_n_in = 1'b1;
		check(32'(irq), 32'h0);
		t_reset();
	endtask
	// A hang is cut short well beyond the few hundred cycles the scenarios need.
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		rst_n_in = 1'b0;
		repeat (4) @(negedge mclk_in);
		rst_n_in = 1'b1;
		check(32'(irq), 32'h0);
		t_reset();
		t_presc();
		t_carry();
		t_bank();
		t_auto();
		t_rerst();
		final_report();
	end
endmodule
`default_nettype wire
